// *** core/fault_manager.sv ***
`timescale 1ns/1ps
`include "fault_map.svh"

module fault_manager #(
	parameter int unsigned LONG_RETRY_CYCLES  = `LONG_RETRY_CYC,
	parameter int unsigned SHORT_RETRY_CYCLES = `SHORT_RETRY_CYC,
	parameter int unsigned BLANK_CYCLES       = `BLANK_CYC,
	parameter int unsigned FET_COUNT          = 6
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 sys_rst_in,
	input  wire logic                 pin_configured_in,
	input  wire logic [2:0]           undervolt_retry_sel_in,
	input  wire logic                 refsupply_monitor_en_in,
	input  wire logic [2:0]           overcurrent_response_sel_in,
	input  wire logic [1:0]           overtemp_retry_sel_in,
	input  wire logic                 thermal_warn_report_en_in,
	input  wire logic                 fault_clear_cmd_in,
	input  wire logic                 sleep_request_pin_n_in,
	input  wire logic                 ldo_input_uv_in,
	input  wire logic                 ldo_output_uv_in,
	input  wire logic                 pump_uv_in,
	input  wire logic                 ref_uv_in,
	input  wire logic [FET_COUNT-1:0] overcurrent_in,
	input  wire logic [FET_COUNT-1:0] phase_cmd_in,
	input  wire logic                 thermal_warn_in,
	input  wire logic                 thermal_shutdown_in,
	input  wire logic                 fault_out_low_in,
	output logic                      fault_out_low_out,
	output logic                      fault_out_low_oe_n_out,
	output logic                      bridge_enable_out,
	output logic                      pump_enable_out,
	output logic                      serial_enable_out,
	output logic                      sense_amp_enable_out,
	output logic                      supply_lost_flag_out,
	output logic                      fault_flag_out,
	output logic                      undervolt_flag_out,
	output logic                      ldo_input_uv_flag_out,
	output logic                      ldo_output_uv_flag_out,
	output logic                      pump_uv_flag_out,
	output logic                      ref_uv_flag_out,
	output logic                      overcurrent_flag_out,
	output logic [FET_COUNT-1:0]      overcurrent_fet_flags_out,
	output logic                      thermal_warn_flag_out,
	output logic                      thermal_shutdown_flag_out,
	output logic                      overtemp_flag_out
);
	fault_pkg::oc_state_t oc_state_q;
	logic                 sleep_prev_q;
	logic                 clear_req;
	logic                 ref_en;
	logic [3:0]           uv_hit;
	logic [3:0]           uv_flag_q;
	logic                 uv_done;
	logic                 uv_long;
	logic [2:0]           oc_mode;
	logic [FET_COUNT-1:0] oc_hit;
	logic                 oc_any;
	logic                 oc_act;
	logic                 oc_stop;
	logic                 oc_done;
	logic                 oc_exit;
	logic                 oc_hz;
	logic                 ot_flag_q;
	logic                 ot_done;
	logic                 ot_hz;
	logic                 drive_hz;
	logic                 pin_low;

	// Pin variants ignore the retry selectors and run the short wait.
	function automatic logic long_sel(input logic       pin,
	                                  input logic [2:0] sel,
	                                  input logic [2:0] code);
		long_sel = !pin && (sel == code);
	endfunction

	// A sleep pin that went low and comes back high acts as fault clear.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sleep_prev_q <= 1'h1;
		end else begin
			sleep_prev_q <= sleep_request_pin_n_in;
		end
	end
	assign clear_req = fault_clear_cmd_in
	                   || (!sleep_prev_q && sleep_request_pin_n_in);

	// Undervoltage sources and their shared retry wait.
	assign ref_en = !pin_configured_in && refsupply_monitor_en_in; // [RULE6]
	assign uv_hit = {ref_uv_in && ref_en, pump_uv_in, // [RULE7]
	                 ldo_output_uv_in, ldo_input_uv_in}; // [RULE5]
	assign uv_long = long_sel(pin_configured_in, undervolt_retry_sel_in,
	                          `UV_SEL_LONG); // [RULE8] [RULE9] [RULE7]

	// A new trip in the done cycle keeps its flag: set wins.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			uv_flag_q <= 4'h0;
		end else begin
			uv_flag_q <= (uv_flag_q & ~{4{uv_done}}) | uv_hit; // [RULE11]
		end
	end

	retry_timer #(
		.LONG_CYCLES  (LONG_RETRY_CYCLES),
		.SHORT_CYCLES (SHORT_RETRY_CYCLES)
	) uv_timer (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.run_in      (|uv_flag_q && !(|uv_hit)),
		.use_long_in (uv_long),
		.done_out    (uv_done)
	);

	// Overcurrent handling after blanking.
	ocp_blanker #(
		.BLANK_CYCLES (BLANK_CYCLES),
		.N            (FET_COUNT)
	) blanker (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.phase_cmd_in (phase_cmd_in),
		.oc_raw_in    (overcurrent_in),
		.oc_hit_out   (oc_hit)
	);

	assign oc_mode = pin_configured_in ? `OC_SEL_SHORT
	                                   : overcurrent_response_sel_in;
	assign oc_any  = |oc_hit;
	// Codes above report-only are treated like the disabled mode.
	assign oc_act  = oc_any && (oc_mode <= `OC_SEL_REPORT); // [RULE17]
	assign oc_stop = oc_act && (oc_mode != `OC_SEL_REPORT);
	assign oc_exit = clear_req && !(|overcurrent_in);

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			oc_state_q <= fault_pkg::OC_RUN;
		end else begin
			case (oc_state_q)
				fault_pkg::OC_RUN: begin
					if (oc_act && oc_mode == `OC_SEL_LATCH) begin
						oc_state_q <= fault_pkg::OC_LATCHED; // [RULE13]
					end else if (oc_act && oc_mode == `OC_SEL_REPORT) begin
						oc_state_q <= fault_pkg::OC_REPORT; // [RULE17]
					end else if (oc_stop) begin
						oc_state_q <= fault_pkg::OC_RETRY; // [RULE16]
					end
				end
				fault_pkg::OC_RETRY: begin
					if (oc_done) begin
						oc_state_q <= fault_pkg::OC_RUN; // [RULE16]
					end
				end
				fault_pkg::OC_LATCHED, fault_pkg::OC_REPORT: begin
					if (oc_exit) begin
						oc_state_q <= fault_pkg::OC_RUN; // [RULE13]
					end
				end
				default: oc_state_q <= fault_pkg::OC_RUN;
			endcase
		end
	end

	retry_timer #(
		.LONG_CYCLES  (LONG_RETRY_CYCLES),
		.SHORT_CYCLES (SHORT_RETRY_CYCLES)
	) oc_timer (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.run_in      (oc_state_q == fault_pkg::OC_RETRY),
		.use_long_in (long_sel(pin_configured_in, oc_mode, `OC_SEL_LONG)),
		.done_out    (oc_done)
	);

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			overcurrent_fet_flags_out <= '0;
		end else if ((oc_state_q == fault_pkg::OC_RETRY && oc_done)
		             || (oc_state_q != fault_pkg::OC_RUN && oc_exit)) begin
			overcurrent_fet_flags_out <= oc_hit; // [RULE16]
		end else if (oc_act) begin
			overcurrent_fet_flags_out <= overcurrent_fet_flags_out | oc_hit;
		end
	end

	// Thermal shutdown and its retry wait after cooling.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ot_flag_q <= 1'h0;
		end else begin
			ot_flag_q <= (ot_flag_q && !ot_done) || thermal_shutdown_in;
		end
	end

	retry_timer #(
		.LONG_CYCLES  (LONG_RETRY_CYCLES),
		.SHORT_CYCLES (SHORT_RETRY_CYCLES)
	) ot_timer (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.run_in      (ot_flag_q && !thermal_shutdown_in), // [RULE14]
		.use_long_in (long_sel(pin_configured_in,
		                       {1'h0, overtemp_retry_sel_in},
		                       {1'h0, `OT_SEL_LONG})), // [RULE14]
		.done_out    (ot_done)
	);

	// Sticky summary flags; a clear in the same cycle as a new event
	// loses to the event.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			fault_flag_out       <= 1'h0;
			undervolt_flag_out   <= 1'h0;
			overcurrent_flag_out <= 1'h0;
			overtemp_flag_out    <= 1'h0;
		end else begin
			fault_flag_out <= |uv_hit || oc_act || thermal_shutdown_in
			                  || (fault_flag_out && !clear_req); // [RULE12]
			undervolt_flag_out <= |uv_hit
			                      || (undervolt_flag_out && !clear_req);
			overcurrent_flag_out <= oc_act
			                        || (overcurrent_flag_out && !clear_req);
			overtemp_flag_out <= thermal_shutdown_in || thermal_warn_in
			                     || (overtemp_flag_out && !clear_req);
		end
	end

	// Comes up low after every supply lockout and stays low until cleared.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			supply_lost_flag_out <= `SUPPLY_LOST_RST; // [RULE3]
		end else if (clear_req) begin
			supply_lost_flag_out <= 1'h1; // [RULE4]
		end
	end

	// Output stage, with present inputs folded in to save a cycle.
	assign oc_hz = (oc_state_q == fault_pkg::OC_RETRY)
	               || (oc_state_q == fault_pkg::OC_LATCHED)
	               || (oc_state_q == fault_pkg::OC_RUN && oc_stop);
	assign ot_hz = ot_flag_q || thermal_shutdown_in;
	assign drive_hz = |uv_flag_q[`UV_PUMP:`UV_LDO_IN]
	                  || |uv_hit[`UV_PUMP:`UV_LDO_IN] || oc_hz || ot_hz;
	assign pin_low = |uv_flag_q || |uv_hit || oc_hz || ot_hz // [RULE20]
	                 || (oc_state_q == fault_pkg::OC_REPORT) || oc_act
	                 || (thermal_warn_report_en_in && thermal_warn_in);

	// Reset is the supply lockout: everything is off while it is held.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bridge_enable_out      <= 1'h0; // [RULE1]
			pump_enable_out        <= 1'h0; // [RULE1]
			serial_enable_out      <= 1'h0;
			sense_amp_enable_out   <= 1'h0;
			fault_out_low_oe_n_out <= 1'h1;
			fault_out_low_out      <= 1'h0;
		end else begin
			bridge_enable_out <= !drive_hz; // [RULE2] [RULE10]
			pump_enable_out <= !(uv_flag_q[`UV_PUMP] || uv_hit[`UV_PUMP]
			                     || ot_hz);
			serial_enable_out <= !(|uv_flag_q[`UV_LDO_OUT:`UV_LDO_IN]
			                       || |uv_hit[`UV_LDO_OUT:`UV_LDO_IN]);
			sense_amp_enable_out <= !(uv_flag_q[`UV_REF]
			                          || uv_hit[`UV_REF]); // [RULE18]
			fault_out_low_oe_n_out <= !pin_low; // [RULE15] [RULE20]
			fault_out_low_out      <= 1'h0;
		end
	end

	assign ldo_input_uv_flag_out  = uv_flag_q[`UV_LDO_IN];
	assign ldo_output_uv_flag_out = uv_flag_q[`UV_LDO_OUT];
	assign pump_uv_flag_out       = uv_flag_q[`UV_PUMP];
	assign ref_uv_flag_out        = uv_flag_q[`UV_REF];
	assign thermal_shutdown_flag_out = ot_flag_q;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			thermal_warn_flag_out <= 1'h0;
		end else begin
			thermal_warn_flag_out <= thermal_warn_in; // [RULE15]
		end
	end

	a_reset_all_off: assert property ( // [RULE1]
		@(posedge clk_sys_in)
		sys_rst_in |=> !bridge_enable_out && !pump_enable_out
		               && fault_out_low_oe_n_out
	) else $error("outputs active during supply lockout");

	a_ldo_in_trip: assert property ( // [RULE10]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		ldo_input_uv_in |=> !bridge_enable_out && !serial_enable_out
		    && !fault_out_low_oe_n_out && ldo_input_uv_flag_out
		    && fault_flag_out && undervolt_flag_out
	) else $error("regulator input trip not acted on");

	a_uv_recover: assert property ( // [RULE11]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		uv_done && !(|uv_hit) |=> uv_flag_q == 4'h0
	) else $error("undervoltage flags not cleared after retry");

	a_summary_sticky: assert property ( // [RULE12]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		fault_flag_out && !clear_req |=> fault_flag_out
	) else $error("summary fault flag dropped without clear");

	a_lost_hold: assert property ( // [RULE4]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		!supply_lost_flag_out && !clear_req |=> !supply_lost_flag_out
	) else $error("supply lost flag left reset state alone");

	a_ref_gated: assert property ( // [RULE6]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		!ref_en && !uv_flag_q[`UV_REF] |=> !ref_uv_flag_out
	) else $error("reference monitor tripped while disabled");

	a_ref_sense_off: assert property ( // [RULE18]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		ref_uv_in && ref_en |=> !sense_amp_enable_out && ref_uv_flag_out
	) else $error("reference trip left sense amplifiers on");

	a_latch_hold: assert property ( // [RULE13]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		oc_state_q == fault_pkg::OC_LATCHED && !clear_req
		|=> oc_state_q == fault_pkg::OC_LATCHED && !bridge_enable_out
	) else $error("latched overcurrent released without clear");

	a_ot_bridge_off: assert property ( // [RULE14]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		ot_flag_q |=> !bridge_enable_out && !pump_enable_out
	) else $error("bridges on during thermal shutdown");

	a_warn_pin: assert property ( // [RULE15]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		thermal_warn_report_en_in && thermal_warn_in
		|=> !fault_out_low_oe_n_out
	) else $error("thermal warning not reported on pin");

	a_oc_off_quiet: assert property ( // [RULE17]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		oc_mode == `OC_SEL_OFF && oc_state_q == fault_pkg::OC_RUN
		&& !overcurrent_flag_out |=> !overcurrent_flag_out
	) else $error("disabled overcurrent mode reacted");

	a_retry_exit: assert property ( // [RULE16]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		oc_state_q == fault_pkg::OC_RETRY && oc_done
		|=> oc_state_q == fault_pkg::OC_RUN
	) else $error("overcurrent retry did not resume");
endmodule // fault_manager

// *** core/fault_map.svh ***
// Overview of operation
// RULE1: Supply lockout disables bridges, pump and logic.
// RULE2: Driving resumes by itself after lockout ends.
// RULE3: Supply-lost flag comes up latched low.
// RULE4: Only fault clear or sleep pulse releases it.
// RULE5: Regulator and pump monitors are always enabled.
// RULE6: Reference monitor off unless its enable set.
// RULE7: Pin variants use short retry, no reference.
// RULE8: Undervoltage selector 000b selects long retry.
// RULE9: Undervoltage selector 001b selects short retry.
// RULE10: Regulator-input trip stops bridges, serial, pulls pin.
// RULE11: After recovery and wait, driving resumes automatically.
// RULE12: Summary flags stay set until fault clear.
// RULE13: Overcurrent 010b latches bridges off until clear.
// RULE14: Overtemperature holds bridges off, then timed retry.
// RULE15: Enabled warning pulls pin while hot, bridges run.
// RULE16: Overcurrent retry modes clear transistor flags after wait.
// RULE17: Report-only keeps driving; disabled mode does nothing.
// RULE18: Reference trip stops sense amplifiers only.
// RULE19: Overcurrent ignored during blanking after phase edges.
// RULE20: Fault pin is OR of reporting sources.
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

`define CLK_NS          25
`define CLK_MHZ         40
`define SHORT_RETRY_US  5000
`define LONG_RETRY_US   50000
`define BLANK_NS        200
`define SHORT_RETRY_CYC (`SHORT_RETRY_US * `CLK_MHZ)
`define LONG_RETRY_CYC  (`LONG_RETRY_US * `CLK_MHZ)
`define BLANK_CYC       ((`BLANK_NS + `CLK_NS - 1) / `CLK_NS)

`define UV_SEL_LONG     3'h0
`define OC_SEL_LONG     3'h0
`define OC_SEL_SHORT    3'h1
`define OC_SEL_LATCH    3'h2
`define OC_SEL_REPORT   3'h3
`define OC_SEL_OFF      3'h7
`define OT_SEL_LONG     2'h0

`define UV_LDO_IN       0
`define UV_LDO_OUT      1
`define UV_PUMP         2
`define UV_REF          3
`define SUPPLY_LOST_RST 1'h0

`endif

// *** core/fault_pkg.sv ***
package fault_pkg;
	typedef enum logic [3:0] {
		OC_RUN     = 4'h1,
		OC_RETRY   = 4'h2,
		OC_LATCHED = 4'h4,
		OC_REPORT  = 4'h8
	} oc_state_t;
endpackage

// *** core/retry_timer.sv ***
`timescale 1ns/1ps
`include "fault_map.svh"

module retry_timer #(
	parameter int unsigned LONG_CYCLES  = `LONG_RETRY_CYC,
	parameter int unsigned SHORT_CYCLES = `SHORT_RETRY_CYC
) (
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	input  wire logic run_in,
	input  wire logic use_long_in,
	output logic      done_out
);
	logic [31:0] count_q;
	logic [31:0] limit;

	assign limit = use_long_in ? LONG_CYCLES[31:0] : SHORT_CYCLES[31:0];

	// Any interruption of run_in restarts the wait from zero.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || !run_in) begin
			count_q  <= 32'h0;
			done_out <= 1'h0;
		end else if (count_q >= limit - 32'h1) begin
			count_q  <= 32'h0;
			done_out <= 1'h1;
		end else begin
			count_q  <= count_q + 32'h1;
			done_out <= 1'h0;
		end
	end

	a_done_after_wait: assert property ( // [RULE11]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		$rose(done_out) |-> $past(count_q) >= $past(limit) - 32'h1
	) else $error("retry done before wait elapsed");
endmodule // retry_timer

// *** core/ocp_blanker.sv ***
`timescale 1ns/1ps
`include "fault_map.svh"

module ocp_blanker #(
	parameter int unsigned BLANK_CYCLES = `BLANK_CYC,
	parameter int unsigned N            = 6
) (
	input  wire logic         clk_sys_in,
	input  wire logic         sys_rst_in,
	input  wire logic [N-1:0] phase_cmd_in,
	input  wire logic [N-1:0] oc_raw_in,
	output logic      [N-1:0] oc_hit_out
);
	logic [N-1:0] prev_q;
	logic [7:0]   cnt_q;
	logic         edge_seen;

	assign edge_seen = |(phase_cmd_in ^ prev_q);

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			// Loading the present commands keeps reset from looking like
			// a switching edge and opening a needless blanking window.
			prev_q <= phase_cmd_in;
		end else begin
			prev_q <= phase_cmd_in;
		end
	end

	// Ringing after a switching edge must not look like overcurrent.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cnt_q      <= 8'h0;
			oc_hit_out <= '0;
		end else begin
			if (edge_seen) begin
				cnt_q <= BLANK_CYCLES[7:0]; // [RULE19]
			end else if (cnt_q != 8'h0) begin
				cnt_q <= cnt_q - 8'h1;
			end
			if (edge_seen || cnt_q != 8'h0) begin
				oc_hit_out <= '0; // [RULE19]
			end else begin
				oc_hit_out <= oc_raw_in;
			end
		end
	end

	a_blank_mask: assert property ( // [RULE19]
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		edge_seen |=> (oc_hit_out == '0) [*2]
	) else $error("overcurrent passed during blanking");
endmodule // ocp_blanker

// *** bench/mcu_model.sv ***
`timescale 1ns/1ps

// Host controller on the far side of the fault pin and the clear inputs.
module mcu_model (
	input  wire logic clk_sys_in,
	input  wire logic fault_oe_n_in,
	output logic      fault_clear_cmd_out,
	output logic      sleep_n_out,
	output wire logic pin_level_out
);
	// The pin has an external pull-up, so it reads high unless the device
	// sinks it.
	assign pin_level_out = (fault_oe_n_in === 1'b0) ? 1'b0 : 1'b1;

	initial begin
		fault_clear_cmd_out = 1'b0;
		sleep_n_out = 1'b1;
	end

	task automatic clear_fault();
		@(posedge clk_sys_in);
		fault_clear_cmd_out <= 1'b1;
		@(posedge clk_sys_in);
		fault_clear_cmd_out <= 1'b0;
	endtask

	// The low phase lasts several cycles; only the rising edge clears.
	task automatic sleep_pulse();
		@(posedge clk_sys_in);
		sleep_n_out <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		sleep_n_out <= 1'b1;
	endtask
endmodule // mcu_model

// *** bench/fault_manager_tb_top.sv ***
`timescale 1ns/1ps

`define CK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
$display("wrong value %s exp %0h got %0h", nm, e, g); err_total++; end end

module fault_manager_tb_top;
	localparam int LONG = 20;
	localparam int SHORT = 8;
	logic		clk_sys_in = 1'b0;
	logic		sys_rst_in = 1'b1;
	logic		pin_configured_in = 1'b0;
	logic [2:0]	undervolt_retry_sel_in = 3'h0;
	logic		refsupply_monitor_en_in = 1'b0;
	logic [2:0]	overcurrent_response_sel_in = 3'h3;
	logic [1:0]	overtemp_retry_sel_in = 2'h0;
	logic		thermal_warn_report_en_in = 1'b0;
	logic		ldo_input_uv_in = 1'b0;
	logic		ldo_output_uv_in = 1'b0;
	logic		pump_uv_in = 1'b0;
	logic		ref_uv_in = 1'b0;
	logic [5:0]	overcurrent_in = 6'h00;
	logic [5:0]	phase_cmd_in = 6'h15;
	logic		thermal_warn_in = 1'b0;
	logic		thermal_shutdown_in = 1'b0;
	logic		fault_clear_cmd_in;
	logic		sleep_request_pin_n_in;
	wire logic	fault_out_low_in;
	logic		fault_out_low_oe_n_out;
	logic		bridge_enable_out;
	logic		pump_enable_out;
	logic		serial_enable_out;
	logic		sense_amp_enable_out;
	logic		supply_lost_flag_out;
	logic		fault_flag_out;
	logic		undervolt_flag_out;
	logic		ldo_input_uv_flag_out;
	logic		ref_uv_flag_out;
	logic		overcurrent_flag_out;
	logic [5:0]	overcurrent_fet_flags_out;
	logic		fault_out_low_out;
	logic		ldo_output_uv_flag_out;
	logic		pump_uv_flag_out;
	logic		thermal_warn_flag_out;
	logic		thermal_shutdown_flag_out;
	logic		overtemp_flag_out;
	int		err_total = 0;
	int		n_tests = 0;
	int		cyc = 0;
	int		rec_n;

	always #12.5 clk_sys_in = ~clk_sys_in;

	fault_manager #(.LONG_RETRY_CYCLES(LONG), .SHORT_RETRY_CYCLES(SHORT)) uut (
		.clk_sys_in, .sys_rst_in, .pin_configured_in, .undervolt_retry_sel_in,
		.refsupply_monitor_en_in, .overcurrent_response_sel_in,
		.overtemp_retry_sel_in, .thermal_warn_report_en_in,
		.fault_clear_cmd_in, .sleep_request_pin_n_in, .ldo_input_uv_in,
		.ldo_output_uv_in, .pump_uv_in, .ref_uv_in, .overcurrent_in,
		.phase_cmd_in, .thermal_warn_in, .thermal_shutdown_in,
		.fault_out_low_in, .fault_out_low_out, .fault_out_low_oe_n_out,
		.bridge_enable_out, .pump_enable_out, .serial_enable_out,
		.sense_amp_enable_out, .supply_lost_flag_out, .fault_flag_out,
		.undervolt_flag_out, .ldo_input_uv_flag_out,
		.ldo_output_uv_flag_out, .pump_uv_flag_out, .ref_uv_flag_out,
		.overcurrent_flag_out, .overcurrent_fet_flags_out,
		.thermal_warn_flag_out, .thermal_shutdown_flag_out,
		.overtemp_flag_out);

	mcu_model mcu (.clk_sys_in, .fault_oe_n_in(fault_out_low_oe_n_out),
		.fault_clear_cmd_out(fault_clear_cmd_in),
		.sleep_n_out(sleep_request_pin_n_in),
		.pin_level_out(fault_out_low_in));

	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	// Counts edges until the bridges come back, bounded so a stuck design
	// still ends the scenario.
	task automatic rec();
		rec_n = 0;
		while (bridge_enable_out !== 1'b1 && rec_n < 80) begin
			tk(1);
			rec_n++;
		end
	endtask

	task automatic t_reset();
		tk(2);
		`CK("bridge", 1'b1, bridge_enable_out)
		`CK("pump", 1'b1, pump_enable_out)
		`CK("pin drive", 1'b0, fault_out_low_out)
		`CK("lost", 1'b0, supply_lost_flag_out)
		tk(10);
		`CK("lost", 1'b0, supply_lost_flag_out)
		mcu.clear_fault();
		tk(2);
		`CK("lost", 1'b1, supply_lost_flag_out)
		@(posedge clk_sys_in) sys_rst_in <= 1'b1;
		tk(3);
		`CK("bridge", 1'b0, bridge_enable_out)
		`CK("pump", 1'b0, pump_enable_out)
		`CK("serial", 1'b0, serial_enable_out)
		@(posedge clk_sys_in) sys_rst_in <= 1'b0;
		tk(3);
		`CK("bridge", 1'b1, bridge_enable_out)
		`CK("lost", 1'b0, supply_lost_flag_out)
		mcu.sleep_pulse();
		tk(2);
		`CK("lost", 1'b1, supply_lost_flag_out)
		$display("test reset done");
	endtask

	task automatic t_uv();
		int lim;
		for (int i = 0; i < 4; i++) begin
			lim = (i == 0) ? LONG : SHORT;
			@(posedge clk_sys_in);
			undervolt_retry_sel_in <= (i == 1 || i == 2) ? 3'h1 : 3'h0;
			pin_configured_in <= (i == 3);
			ldo_input_uv_in <= (i == 0 || i == 3);
			ldo_output_uv_in <= (i == 1);
			pump_uv_in <= (i == 2);
			tk(2);
			`CK("bridge", 1'b0, bridge_enable_out)
			`CK("pin", 1'b0, fault_out_low_in)
			`CK("undervolt", 1'b1, undervolt_flag_out)
			`CK("ldo out", i == 1, ldo_output_uv_flag_out)
			`CK("pump uv", i == 2, pump_uv_flag_out)
			if (i == 0) begin
				`CK("serial", 1'b0, serial_enable_out)
				`CK("ldo in", 1'b1, ldo_input_uv_flag_out)
			end
			@(posedge clk_sys_in);
			ldo_input_uv_in <= 1'b0;
			ldo_output_uv_in <= 1'b0;
			pump_uv_in <= 1'b0;
			rec();
			`CK("wait", 1'b1, rec_n >= lim && rec_n <= lim + 6)
			`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
			`CK("ldo in", 1'b0, ldo_input_uv_flag_out)
			`CK("pump uv", 1'b0, pump_uv_flag_out)
			`CK("fault", 1'b1, fault_flag_out)
			if (i == 3) mcu.sleep_pulse();
			else mcu.clear_fault();
			tk(2);
			`CK("undervolt", 1'b0, undervolt_flag_out)
		end
		@(posedge clk_sys_in) pin_configured_in <= 1'b0;
		$display("test undervoltage done");
	endtask

	task automatic t_ref();
		@(posedge clk_sys_in) ref_uv_in <= 1'b1;
		tk(3);
		`CK("sense", 1'b1, sense_amp_enable_out)
		`CK("ref", 1'b0, ref_uv_flag_out)
		@(posedge clk_sys_in);
		refsupply_monitor_en_in <= 1'b1;
		pin_configured_in <= 1'b1;
		tk(3);
		`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
		@(posedge clk_sys_in) pin_configured_in <= 1'b0;
		tk(2);
		`CK("sense", 1'b0, sense_amp_enable_out)
		`CK("bridge", 1'b1, bridge_enable_out)
		`CK("oe_n", 1'b0, fault_out_low_oe_n_out)
		`CK("ref", 1'b1, ref_uv_flag_out)
		@(posedge clk_sys_in) ref_uv_in <= 1'b0;
		tk(LONG + 10);
		`CK("sense", 1'b1, sense_amp_enable_out)
		mcu.clear_fault();
		$display("test reference done");
	endtask

	task automatic t_oc();
		logic [2:0] m;
		int lim;
		// An overcurrent at a phase edge must leave no trace at all.
		@(posedge clk_sys_in);
		phase_cmd_in <= ~phase_cmd_in;
		overcurrent_in <= 6'h01;
		repeat (3) @(posedge clk_sys_in);
		overcurrent_in <= 6'h00;
		tk(6);
		`CK("oc", 1'b0, overcurrent_flag_out)
		`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
		for (int j = 0; j < 5; j++) begin
			m = (j < 3) ? 3'h2 + 3'(j) : 3'(j - 3);
			if (m == 3'h4) m = 3'h7;
			lim = (m == 3'h0) ? LONG : SHORT;
			@(posedge clk_sys_in);
			overcurrent_response_sel_in <= m;
			overcurrent_in <= 6'h04;
			tk(5);
			`CK("bridge", m == 3'h3 || m == 3'h7, bridge_enable_out)
			`CK("oe_n", m == 3'h7, fault_out_low_oe_n_out)
			`CK("fets", m == 3'h7 ? 6'h00 : 6'h04, overcurrent_fet_flags_out)
			@(posedge clk_sys_in) overcurrent_in <= 6'h00;
			if (m < 3'h2) begin
				rec();
				`CK("wait", 1'b1, rec_n >= lim - 4 && rec_n <= lim + 4)
				`CK("fets", 6'h00, overcurrent_fet_flags_out)
			end
			tk(30);
			`CK("bridge", m != 3'h2, bridge_enable_out)
			`CK("oc", m != 3'h7, overcurrent_flag_out)
			`CK("oe_n", m != 3'h2 && m != 3'h3, fault_out_low_oe_n_out)
			mcu.clear_fault();
			tk(3);
			`CK("bridge", 1'b1, bridge_enable_out)
			`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
		end
		$display("test overcurrent done");
	endtask

	task automatic t_ot();
		@(posedge clk_sys_in) thermal_warn_in <= 1'b1;
		tk(3);
		`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
		@(posedge clk_sys_in) thermal_warn_report_en_in <= 1'b1;
		tk(3);
		`CK("oe_n", 1'b0, fault_out_low_oe_n_out)
		`CK("bridge", 1'b1, bridge_enable_out)
		`CK("warn", 1'b1, thermal_warn_flag_out)
		@(posedge clk_sys_in) thermal_warn_in <= 1'b0;
		tk(3);
		`CK("oe_n", 1'b1, fault_out_low_oe_n_out)
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_sys_in);
			overtemp_retry_sel_in <= 2'(s);
			thermal_shutdown_in <= 1'b1;
			tk(3);
			`CK("bridge", 1'b0, bridge_enable_out)
			`CK("oe_n", 1'b0, fault_out_low_oe_n_out)
			`CK("thermal_shutdown_flag", 1'b1, thermal_shutdown_flag_out)
			@(posedge clk_sys_in) thermal_shutdown_in <= 1'b0;
			rec();
			`CK("wait", 1'b1, rec_n >= (s ? SHORT : LONG) && rec_n <= (s ? SHORT : LONG) + 6)
			`CK("thermal_shutdown_flag", 1'b0, thermal_shutdown_flag_out)
			`CK("ot", 1'b1, overtemp_flag_out)
			mcu.clear_fault();
			tk(2);
			`CK("ot", 1'b0, overtemp_flag_out)
		end
		$display("test thermal done");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_uv();
		t_ref();
		t_oc();
		t_ot();
		stop_test();
	end
endmodule // fault_manager_tb_top
